// ### hw/mtc_pkg.sv
package mtc_pkg;

    // ------------------------------------------------------------
    // Register map (byte-wide registers, one index each)
    // ------------------------------------------------------------
    localparam int          ADDR_W           = 3;
    localparam logic [2:0]  OFS_STATUS_CTRL  = 3'h0;
    localparam logic [2:0]  OFS_COUNT_HIGH   = 3'h1;
    localparam logic [2:0]  OFS_COUNT_LOW    = 3'h2;
    localparam logic [2:0]  OFS_MODULO_HIGH  = 3'h3;
    localparam logic [2:0]  OFS_MODULO_LOW   = 3'h4;
    localparam logic [2:0]  OFS_CHANNEL      = 3'h5;

    // ------------------------------------------------------------
    // Status/control field positions
    // ------------------------------------------------------------
    localparam int          BIT_WRAP_FLAG    = 7;
    localparam int          BIT_WRAP_IE      = 6;
    localparam int          BIT_HALT         = 5;
    localparam int          BIT_CNT_RESET    = 4;
    localparam int          SEL_LSB          = 0;
    localparam int          SEL_W            = 3;
    localparam int          CH_FLAG_LSB      = 0;
    localparam int          CH_IE_LSB        = 4;
    localparam int          NUM_CH           = 4;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [2:0]  SEL_RESET        = 3'h0;
    localparam logic [2:0]  SEL_EXT_CLOCK    = 3'h7;
    localparam logic [15:0] MODULO_RESET     = 16'hFFFF;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    localparam logic [7:0]  READ_ZERO        = 8'h00;
    localparam int          PRE_W            = 6;

    typedef struct packed {
        logic [15:0]       count;
        logic [15:0]       modulo;
        logic [PRE_W-1:0]  pre;
        logic              wrap_flag;
        logic              wrap_arm;
        logic              wrap_irq_enable;
        logic              count_halt;
        logic [SEL_W-1:0]  clock_divider_select;
        logic              modulo_pending;
        logic [7:0]        held_low;
        logic              held_valid;
        logic [NUM_CH-1:0] channel_event_flags;
        logic [NUM_CH-1:0] channel_arm;
        logic [NUM_CH-1:0] channel_irq_enable;
        logic [2:0]        ext_sync;
        logic [7:0]        rdata;
    } mtc_state_type;

endpackage : mtc_pkg

// ### hw/mtc_core.sv
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module mtc_core
    import mtc_pkg::*;
(
    input  wire logic              CORE_CLK,
    input  wire logic              RST_N,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [7:0]        WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [7:0]        RDATA,
    input  wire logic              WAIT_MODE,
    input  wire logic              STOP_MODE,
    input  wire logic              BREAK_ACTIVE,
    input  wire logic              BREAK_CLEAR_ALLOW,
    input  wire logic [NUM_CH-1:0] CH_EVENT,
    input  wire logic              EXT_CLK_PIN_IN,
    input  wire logic              PORT_DIR_BIT,
    input  wire logic              PORT_DATA_OUT,
    output logic                   EXT_CLK_PIN_OUT,
    output logic                   EXT_CLK_PIN_OE,
    output logic                   IRQ,
    output logic                   WAKE_REQ
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    mtc_state_type s_q;
    mtc_state_type s_d;

    logic          acc_ok;
    logic          clr_ok;
    logic          wr_stat;
    logic          rd_stat;
    logic          cnt_reset;
    logic          run;
    logic          ext_sel;
    logic          ext_edge;
    logic          tick;
    logic          match;
    logic          wrap_set;
    logic [7:0]    rd_val;

    // Mask of prescaler bits that must all be one for a tick at a given division
    function automatic logic [PRE_W-1:0] div_mask(input logic [SEL_W-1:0] sel);
        div_mask = PRE_W'((7'h01 << sel) - 7'h01);
    endfunction : div_mask

    // ------------------------------------------------------------
    // Access qualifiers and counter clocking
    // ------------------------------------------------------------
    assign acc_ok    = ~WAIT_MODE;
    assign clr_ok    = ~BREAK_ACTIVE | BREAK_CLEAR_ALLOW;
    assign wr_stat   = WR & acc_ok & (ADDR == OFS_STATUS_CTRL);
    assign rd_stat   = RD & acc_ok & (ADDR == OFS_STATUS_CTRL);
    assign cnt_reset = wr_stat & WDATA[BIT_CNT_RESET];
    // Stop mode and break freeze prescaler and counter without touching contents
    assign run       = ~s_q.count_halt & ~STOP_MODE & ~BREAK_ACTIVE;
    assign ext_sel   = (s_q.clock_divider_select == SEL_EXT_CLOCK);
    // Edge taken between second and third stage so the first stage feeds nothing else
    assign ext_edge  = s_q.ext_sync[1] & ~s_q.ext_sync[2];
    assign tick      = run & (ext_sel ? ext_edge
                                      : ((s_q.pre & div_mask(s_q.clock_divider_select))
                                         == div_mask(s_q.clock_divider_select)));
    assign match     = (s_q.count == s_q.modulo);
    assign wrap_set  = tick & match & ~cnt_reset & ~s_q.modulo_pending;

    // ------------------------------------------------------------
    // Pins and interrupt
    // ------------------------------------------------------------
    assign EXT_CLK_PIN_OUT = PORT_DATA_OUT;
    assign EXT_CLK_PIN_OE  = PORT_DIR_BIT & ~ext_sel;
    assign IRQ      = (s_q.wrap_flag & s_q.wrap_irq_enable)
                    | (|(s_q.channel_event_flags & s_q.channel_irq_enable));
    assign WAKE_REQ = IRQ & WAIT_MODE;
    assign RDATA    = s_q.rdata;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        rd_val    = READ_ZERO;
        s_d.ext_sync = {s_q.ext_sync[1:0], EXT_CLK_PIN_IN};

        // Prescaler runs only with the counter so a halted count restarts in phase
        if (run) begin
            s_d.pre = PRE_W'(s_q.pre + PRE_W'(1));
        end
        if (tick) begin
            s_d.count = match ? COUNT_RESET : 16'(s_q.count + 16'h0001);
        end

        // Counter reset wins over a tick in the same cycle
        if (cnt_reset) begin
            s_d.count = COUNT_RESET;
            s_d.pre   = '0;
        end

        // Wrap flag: two-step clear, a new wrap cancels any pending clear
        if (rd_stat && s_q.wrap_flag && clr_ok) begin
            s_d.wrap_arm = 1'b1;
        end
        if (wr_stat) begin
            s_d.wrap_irq_enable      = WDATA[BIT_WRAP_IE];
            s_d.count_halt           = WDATA[BIT_HALT];
            s_d.clock_divider_select = WDATA[SEL_LSB +: SEL_W];
            if (!WDATA[BIT_WRAP_FLAG] && s_q.wrap_arm && clr_ok) begin
                s_d.wrap_flag = 1'b0;
                s_d.wrap_arm  = 1'b0;
            end
        end
        if (wrap_set) begin
            s_d.wrap_flag = 1'b1;
            s_d.wrap_arm  = 1'b0;
        end

        // Modulo writes; the high byte arms suppression until the low byte lands
        if (WR && acc_ok && ADDR == OFS_MODULO_HIGH) begin
            s_d.modulo[15:8]   = WDATA;
            s_d.modulo_pending = 1'b1;
        end
        if (WR && acc_ok && ADDR == OFS_MODULO_LOW) begin
            s_d.modulo[7:0]    = WDATA;
            s_d.modulo_pending = 1'b0;
        end

        // Channel flags, same two-step clear as the wrap flag
        for (int i = 0; i < NUM_CH; i++) begin
            if (RD && acc_ok && ADDR == OFS_CHANNEL && s_q.channel_event_flags[i] && clr_ok) begin
                s_d.channel_arm[i] = 1'b1;
            end
            if (WR && acc_ok && ADDR == OFS_CHANNEL) begin
                s_d.channel_irq_enable[i] = WDATA[CH_IE_LSB + i];
                if (!WDATA[CH_FLAG_LSB + i] && s_q.channel_arm[i] && clr_ok) begin
                    s_d.channel_event_flags[i] = 1'b0;
                    s_d.channel_arm[i]         = 1'b0;
                end
            end
            if (CH_EVENT[i]) begin
                s_d.channel_event_flags[i] = 1'b1;
                s_d.channel_arm[i]         = 1'b0;
            end
        end

        // Read mux and the low-byte holding latch
        if (RD && acc_ok) begin
            unique case (ADDR)
                OFS_STATUS_CTRL: begin
                    rd_val = {s_q.wrap_flag, s_q.wrap_irq_enable, s_q.count_halt, 2'b00,
                              s_q.clock_divider_select};
                end
                OFS_COUNT_HIGH: begin
                    rd_val = s_q.count[15:8];
                    if (!s_q.held_valid) begin
                        s_d.held_low   = s_q.count[7:0];
                        s_d.held_valid = 1'b1;
                    end
                end
                OFS_COUNT_LOW: begin
                    rd_val         = s_q.held_valid ? s_q.held_low : s_q.count[7:0];
                    s_d.held_valid = 1'b0;
                end
                OFS_MODULO_HIGH: begin
                    rd_val = s_q.modulo[15:8];
                end
                OFS_MODULO_LOW: begin
                    rd_val = s_q.modulo[7:0];
                end
                OFS_CHANNEL: begin
                    rd_val = {s_q.channel_irq_enable, s_q.channel_event_flags};
                end
                default: begin
                    rd_val = READ_ZERO;
                end
            endcase
        end
        s_d.rdata = rd_val;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            s_q.count                <= COUNT_RESET;
            s_q.modulo               <= MODULO_RESET;
            s_q.pre                  <= '0;
            s_q.wrap_flag            <= 1'b0;
            s_q.wrap_arm             <= 1'b0;
            s_q.wrap_irq_enable      <= 1'b0;
            s_q.count_halt           <= 1'b1;
            s_q.clock_divider_select <= SEL_RESET;
            s_q.modulo_pending       <= 1'b0;
            s_q.held_low             <= READ_ZERO;
            s_q.held_valid           <= 1'b0;
            s_q.channel_event_flags  <= '0;
            s_q.channel_arm          <= '0;
            s_q.channel_irq_enable   <= '0;
            s_q.ext_sync             <= '0;
            s_q.rdata                <= READ_ZERO;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sequence arm_wrap_s;
        rd_stat && s_q.wrap_flag && clr_ok && !wrap_set;
    endsequence

    sequence clear_write_s;
        wr_stat && !WDATA[BIT_WRAP_FLAG] && clr_ok && !wrap_set;
    endsequence

    wrap_sets_flag_a: assert property (wrap_set |=> s_q.wrap_flag && s_q.count == COUNT_RESET)
        else $error("wrap flag or zero restart missing after match");
    wrap_irq_out_a: assert property (s_q.wrap_flag && s_q.wrap_irq_enable |-> IRQ)
        else $error("wrap interrupt not raised");
    chan_flag_set_a: assert property (CH_EVENT[0] |=> s_q.channel_event_flags[0])
        else $error("channel flag not set by event");
    wait_wake_a: assert property (WAIT_MODE && s_q.wrap_flag && s_q.wrap_irq_enable |-> WAKE_REQ)
        else $error("enabled interrupt does not wake from wait");
    stop_freeze_a: assert property (STOP_MODE && !cnt_reset |=> $stable(s_q.count))
        else $error("counter moved in stop mode");
    break_freeze_a: assert property (BREAK_ACTIVE && !cnt_reset |=> $stable(s_q.count))
        else $error("counter moved during break");
    break_keep_a: assert property (BREAK_ACTIVE && !BREAK_CLEAR_ALLOW && s_q.wrap_flag |=> s_q.wrap_flag)
        else $error("flag cleared during protected break");
    ext_input_a: assert property (ext_sel |-> !EXT_CLK_PIN_OE)
        else $error("external clock pin driven while selected");
    clear_seq_a: assert property (arm_wrap_s ##1 clear_write_s |=> !s_q.wrap_flag)
        else $error("two-step clear did not clear flag");
    no_blind_clr_a: assert property (wr_stat && !s_q.wrap_arm && s_q.wrap_flag |=> s_q.wrap_flag)
        else $error("flag cleared without prior read");
    halt_hold_a: assert property (s_q.count_halt && !cnt_reset |=> $stable(s_q.count))
        else $error("counter moved while halted");
    cnt_reset_a: assert property (cnt_reset |=> s_q.count == COUNT_RESET && s_q.pre == '0)
        else $error("counter reset did not clear");
    div_two_a: assert property (s_q.clock_divider_select == 3'h1 && tick && !ext_sel && !wr_stat |=> !tick)
        else $error("divide by two ticked twice in a row");
    latch_low_a: assert property (RD && acc_ok && ADDR == OFS_COUNT_HIGH && !s_q.held_valid
                                  |=> s_q.held_valid && s_q.held_low == $past(s_q.count[7:0]))
        else $error("low byte not latched on high read");
    pend_block_a: assert property (s_q.modulo_pending && !s_q.wrap_flag |=> !s_q.wrap_flag)
        else $error("wrap flag set while modulo write pending");
    ext_step_a: assert property (ext_sel && run && ext_edge && !match && !cnt_reset
                                 |=> s_q.count == $past(s_q.count) + 16'h0001)
        else $error("external edge did not step counter");

    sequence high_read_s;
        RD && acc_ok && ADDR == OFS_COUNT_HIGH;
    endsequence

    sequence low_read_s;
        RD && acc_ok && ADDR == OFS_COUNT_LOW;
    endsequence

    sequence halt_reset_s;
        cnt_reset && WDATA[BIT_HALT];
    endsequence

    // ------------------------------------------------------------
    // Bus, modes and pins
    // ------------------------------------------------------------
    // Read data falls back to zero so a blocked or idle cycle never shows stale data
    rdata_idle_a: assert property (!(RD && acc_ok) |=> RDATA == READ_ZERO)
        else $error("read data not zero outside a read");

    wait_block_a: assert property (WAIT_MODE && WR |=> $stable(s_q.modulo) && $stable(s_q.count_halt))
        else $error("register written during wait");

    // The count keeps running in wait, otherwise a timer wake could never come
    wait_count_a: assert property (WAIT_MODE && tick && !match && !cnt_reset
                                   |=> s_q.count == $past(s_q.count) + 16'h0001)
        else $error("counter did not advance in wait");

    stop_pre_a: assert property (STOP_MODE && !cnt_reset |=> $stable(s_q.pre))
        else $error("prescaler moved in stop mode");

    break_pre_a: assert property (BREAK_ACTIVE && !cnt_reset |=> $stable(s_q.pre))
        else $error("prescaler moved during break");

    break_arm_a: assert property (BREAK_ACTIVE && !BREAK_CLEAR_ALLOW && s_q.wrap_arm && !wrap_set
                                  |=> s_q.wrap_arm)
        else $error("armed clear lost during protected break");

    ext_idle_a: assert property (ext_sel && !ext_edge && !cnt_reset |=> $stable(s_q.count))
        else $error("counter moved without an external edge");

    pin_gpio_a: assert property (!ext_sel |-> EXT_CLK_PIN_OE == PORT_DIR_BIT)
        else $error("pin direction not under port control");

    one_ignored_a: assert property (wr_stat && WDATA[BIT_WRAP_FLAG] && s_q.wrap_flag |=> s_q.wrap_flag)
        else $error("writing one cleared the wrap flag");

    wrap_disarm_a: assert property (wrap_set |=> !s_q.wrap_arm)
        else $error("new wrap left a pending clear armed");

    reset_reads_a: assert property (rd_stat |=> !RDATA[BIT_CNT_RESET])
        else $error("counter reset bit read back as one");

    halt_zero_a: assert property (halt_reset_s |=> s_q.count_halt && s_q.count == COUNT_RESET)
        else $error("halt with counter reset did not stop at zero");

    sel_zero_a: assert property (run && s_q.clock_divider_select == SEL_RESET |-> tick)
        else $error("undivided clock missed a tick");

    // ------------------------------------------------------------
    // Counter bytes and modulo
    // ------------------------------------------------------------
    high_data_a: assert property (high_read_s |=> RDATA == $past(s_q.count[15:8]))
        else $error("high count byte read back wrong");

    // A latch taken in break must survive the break, so only a low read releases it
    held_keep_a: assert property (s_q.held_valid && !(RD && acc_ok && ADDR == OFS_COUNT_LOW)
                                  |=> s_q.held_valid && $stable(s_q.held_low))
        else $error("held low byte changed before low read");

    low_unlatch_a: assert property (low_read_s |=> !s_q.held_valid)
        else $error("low read left the holding latch set");

    restart_zero_a: assert property (tick && match && !cnt_reset |=> s_q.count == COUNT_RESET)
        else $error("count did not restart from zero after match");

    pend_arm_a: assert property (WR && acc_ok && ADDR == OFS_MODULO_HIGH |=> s_q.modulo_pending)
        else $error("modulo high write did not suppress the flag");

    pend_release_a: assert property (WR && acc_ok && ADDR == OFS_MODULO_LOW |=> !s_q.modulo_pending)
        else $error("modulo low write did not release the flag");

    // ------------------------------------------------------------
    // Channel flags
    // ------------------------------------------------------------
    // One checker set per channel; a flag stands until its channel register is written
    for (genvar g = 0; g < NUM_CH; g++) begin : gen_chan_chk
        chan_set_a: assert property (CH_EVENT[g] |=> s_q.channel_event_flags[g])
            else $error("channel flag not set by its event");

        chan_irq_a: assert property (s_q.channel_event_flags[g] && s_q.channel_irq_enable[g] |-> IRQ)
            else $error("enabled channel flag raised no interrupt");

        chan_keep_a: assert property (s_q.channel_event_flags[g] && !(WR && ADDR == OFS_CHANNEL)
                                      |=> s_q.channel_event_flags[g])
            else $error("channel flag dropped without a clear");
    end

endmodule : mtc_core

// ### testbench/mtc_core_tb_top.sv
`timescale 1ns/10ps
module mtc_core_tb_top;
    import mtc_pkg::*;

    logic              clk, rst_n, wr, rd, wait_mode, stop_mode, brk, brk_allow;
    logic              ext_pin, port_dir, port_out, pin_out, pin_oe, irq, wake;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata, rdata, rv, h;
    logic [NUM_CH-1:0] ch_event;
    logic [15:0]       m, c1, c2;
    logic [31:0]       seed;
    int                fail_count, checks, cyc, e0, e1, eh, k, n;

    mtc_core u_dut (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .WAIT_MODE(wait_mode), .STOP_MODE(stop_mode), .BREAK_ACTIVE(brk),
        .BREAK_CLEAR_ALLOW(brk_allow), .CH_EVENT(ch_event), .EXT_CLK_PIN_IN(ext_pin),
        .PORT_DIR_BIT(port_dir), .PORT_DATA_OUT(port_out), .EXT_CLK_PIN_OUT(pin_out),
        .EXT_CLK_PIN_OE(pin_oe), .IRQ(irq), .WAKE_REQ(wake));

    // ------------------------------------------------------------
    // Clock, edge counter and helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) cyc <= cyc + 1;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict;
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    // One bus cycle; e1 keeps the edge that took it, rv the read data
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= w;
        rd    <= !w;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        e1 = cyc;
        #1 rv = rdata;
    endtask : acc

    task automatic rd_count(output logic [15:0] v);
        acc(1'b0, OFS_COUNT_HIGH, 8'h00);
        h = rv;
        acc(1'b0, OFS_COUNT_LOW, 8'h00);
        v = {h, rv};
    endtask : rd_count

    task automatic set_mod(input logic [15:0] v);
        acc(1'b1, OFS_MODULO_HIGH, v[15:8]);
        acc(1'b1, OFS_MODULO_LOW, v[7:0]);
    endtask : set_mod

    // Running stretch of t idle cycles; k is the number of counting edges
    task automatic run_for(input logic [7:0] ctl, input int t);
        acc(1'b1, OFS_STATUS_CTRL, ctl);
        e0 = e1;
        repeat (t) @(posedge clk);
        acc(1'b1, OFS_STATUS_CTRL, ctl | 8'h20);
        k = e1 - e0;
    endtask : run_for

    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, wr, rd, wait_mode, stop_mode, brk, brk_allow, ext_pin} = '0;
        {port_dir, port_out, addr, wdata, ch_event} = '0;
        seed = 32'h5d2d_7be6;
        cyc = 0;
        fail_count = 0;
        checks = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk(irq, 1'b0);
        acc(1'b0, OFS_STATUS_CTRL, 8'h00);
        chk(rv, 8'h20);
        acc(1'b0, OFS_MODULO_HIGH, 8'h00);
        chk(rv, 8'hff);
        acc(1'b0, OFS_MODULO_LOW, 8'h00);
        chk(rv, 8'hff);
        acc(1'b0, 3'h6, 8'h00);
        chk(rv, 8'h00);
        // Every divider code: count equals counting edges over the ratio
        for (n = 0; n < 7; n++) begin
            seed = xs(seed);
            acc(1'b1, OFS_STATUS_CTRL, 8'h30 | n[7:0]);
            acc(1'b0, OFS_STATUS_CTRL, 8'h00);
            chk(rv, 8'h20 | n[7:0]);
            rd_count(c1);
            chk(c1, 16'h0000);
            run_for(n[7:0], 40 + int'(seed[7:0]));
            rd_count(c1);
            chk(c1, 16'(k >> n));
        end
        // High read latches the low byte; a second high read does not relatch
        seed = xs(seed);
        acc(1'b1, OFS_STATUS_CTRL, 8'h30);
        acc(1'b1, OFS_STATUS_CTRL, 8'h00);
        e0 = e1;
        repeat (260 + int'(seed[7:0])) @(posedge clk);
        acc(1'b0, OFS_COUNT_HIGH, 8'h00);
        eh = e1 - e0 - 1;
        chk(rv, 8'(eh >> 8));
        repeat (5) @(posedge clk);
        acc(1'b0, OFS_COUNT_HIGH, 8'h00);
        repeat (3) @(posedge clk);
        acc(1'b0, OFS_COUNT_LOW, 8'h00);
        chk(rv, 8'(eh));
        // Modulo wrap, suppressed while the modulo pair is half written
        seed = xs(seed);
        m = 16'(4 + seed[4:0]);
        acc(1'b1, OFS_STATUS_CTRL, 8'h30);
        set_mod(m);
        acc(1'b1, OFS_STATUS_CTRL, 8'h30);
        acc(1'b1, OFS_MODULO_HIGH, 8'h00);
        run_for(8'h40, 3 * m);
        rd_count(c1);
        chk(c1, 16'(k % (m + 1)));
        acc(1'b0, OFS_STATUS_CTRL, 8'h00);
        chk(rv[7], 1'b0);
        chk(irq, 1'b0);
        acc(1'b1, OFS_MODULO_LOW, m[7:0]);
        acc(1'b1, OFS_STATUS_CTRL, 8'h70);
        run_for(8'h40, 3 * m);
        rd_count(c1);
        chk(c1, 16'(k % (m + 1)));
        acc(1'b0, OFS_STATUS_CTRL, 8'h00);
        chk(rv, 8'he0);
        chk(irq, 1'b1);
        acc(1'b1, OFS_STATUS_CTRL, 8'he0);
        acc(1'b0, OFS_STATUS_CTRL, 8'h00);
        chk(rv[7], 1'b1);
        acc(1'b1, OFS_STATUS_CTRL, 8'h60);
        acc(1'b0, OFS_STATUS_CTRL, 8'h00);
        chk(rv, 8'h60);
        chk(irq, 1'b0);
        // A wrap between the arming read and the zero write cancels the clear
        acc(1'b1, OFS_STATUS_CTRL, 8'h40);
        repeat (m + 2) @(posedge clk);
        acc(1'b0, OFS_STATUS_CTRL, 8'h00);
        chk(rv[7], 1'b1);
        repeat (m + 3) @(posedge clk);
        acc(1'b1, OFS_STATUS_CTRL, 8'h60);
        acc(1'b0, OFS_STATUS_CTRL, 8'h00);
        chk(rv[7], 1'b1);
        // Wait mode: access blocked, enabled request wakes
        acc(1'b1, OFS_STATUS_CTRL, 8'hc0);
        @(posedge clk) wait_mode <= 1'b1;
        #1 chk(wake, 1'b1);
        acc(1'b0, OFS_STATUS_CTRL, 8'h00);
        chk(rv, 8'h00);
        acc(1'b1, OFS_STATUS_CTRL, 8'h00);
        @(posedge clk) wait_mode <= 1'b0;
        acc(1'b0, OFS_STATUS_CTRL, 8'h00);
        chk(rv, 8'hc0);
        acc(1'b1, OFS_STATUS_CTRL, 8'h60);
        // Break: frozen counter, clear blocked but arm kept
        run_for(8'h40, m + 3);
        acc(1'b0, OFS_STATUS_CTRL, 8'h00);
        @(posedge clk) brk <= 1'b1;
        acc(1'b1, OFS_STATUS_CTRL, 8'h40);
        rd_count(c1);
        repeat (10) @(posedge clk);
        rd_count(c2);
        chk(c2, c1);
        acc(1'b0, OFS_STATUS_CTRL, 8'h00);
        chk(rv[7], 1'b1);
        acc(1'b1, OFS_STATUS_CTRL, 8'h60);
        @(posedge clk) brk <= 1'b0;
        acc(1'b1, OFS_STATUS_CTRL, 8'h60);
        acc(1'b0, OFS_STATUS_CTRL, 8'h00);
        chk(rv[7], 1'b0);
        // Stop mode keeps the counter
        acc(1'b1, OFS_STATUS_CTRL, 8'h40);
        @(posedge clk) stop_mode <= 1'b1;
        rd_count(c1);
        repeat (10) @(posedge clk);
        rd_count(c2);
        chk(c2, c1);
        @(posedge clk) stop_mode <= 1'b0;
        acc(1'b1, OFS_STATUS_CTRL, 8'h20);
        // Channel flags request only when enabled
        for (n = 0; n < NUM_CH; n++) begin
            @(posedge clk) ch_event <= 4'(1 << n);
            @(posedge clk) ch_event <= 4'h0;
            repeat (2) @(posedge clk);
            #1 chk(irq, 1'b0);
            acc(1'b0, OFS_CHANNEL, 8'h00);
            chk(rv, 8'(1 << n));
            acc(1'b1, OFS_CHANNEL, 8'(8'h11 << n));
            chk(irq, 1'b1);
            acc(1'b1, OFS_CHANNEL, 8'h00);
            acc(1'b0, OFS_CHANNEL, 8'h00);
            chk(rv, 8'h00);
        end
        // External pin as count clock, no faster than half the bus clock
        seed = xs(seed);
        @(posedge clk) port_dir <= 1'b1;
        port_out <= seed[8];
        acc(1'b1, OFS_STATUS_CTRL, 8'h30);
        chk(pin_oe, 1'b1);
        chk(pin_out, seed[8]);
        acc(1'b1, OFS_STATUS_CTRL, 8'h37);
        chk(pin_oe, 1'b0);
        set_mod(16'hffff);
        acc(1'b1, OFS_STATUS_CTRL, 8'h07);
        k = 3 + int'(seed[3:0]);
        repeat (k) begin
            @(posedge clk) ext_pin <= 1'b1;
            repeat (3) @(posedge clk);
            ext_pin <= 1'b0;
            repeat (3) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        acc(1'b1, OFS_STATUS_CTRL, 8'h27);
        rd_count(c1);
        chk(c1, 16'(k));
        print_verdict();
    end
endmodule : mtc_core_tb_top
